// [nssc_pkg.sv]
// package of constants and carriers for the nibble swap and subtract datapath
package nssc_pkg;

  localparam int unsigned DATA_W        = 8;
  localparam int unsigned NIBBLE_W      = 4;
  localparam int unsigned FILE_ADDR_W   = 7;
  localparam logic        DEST_ACC      = 1'b0;
  localparam logic        DEST_FILE     = 1'b1;
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic        CARRY_RESET   = 1'b0;
  localparam int unsigned OP_CYCLES     = 1;

  typedef enum logic [1:0] {
    NSSC_OP_NONE,
    NSSC_OP_SWAP,
    NSSC_OP_SUB_LIT,
    NSSC_OP_SUB_REG
  } nssc_op_e;

  // one instruction as issued by decode
  typedef struct packed {
    logic                   valid;
    nssc_op_e               op;
    logic                   dest;
    logic [FILE_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]      file_data;
    logic [DATA_W-1:0]      literal;
  } nssc_req_s;

  // file register write-back port
  typedef struct packed {
    logic                   we;
    logic [FILE_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]      data;
  } nssc_fwr_s;

endpackage

// [nssc_datapath.sv]
// nibble swap and subtract datapath with accumulator and carry flag
//
// How it works
// - swap exchanges upper and lower nibbles
// - swap dest 0 writes accumulator only
// - swap dest 1 writes back same register
// - positive difference sets carry
// - zero difference sets carry
// - negative difference clears carry, wraps result
// - literal minus accumulator always to accumulator
// - register minus accumulator, dest selects target
`timescale 1ns/100ps

module nssc_datapath #(
  parameter int unsigned DATA_W = nssc_pkg::DATA_W
) (
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  input  wire nssc_pkg::nssc_req_s i_req,
  output nssc_pkg::nssc_fwr_s     o_file_wr,
  output logic [DATA_W-1:0]       o_acc,
  output logic                    o_carry,
  output logic                    o_done
);

  // the carriers and the helper functions are tied to the package width
  if (DATA_W != nssc_pkg::DATA_W) begin : g_width_check
    $error("nssc_datapath: DATA_W must equal the package data width");
  end
  // the swap needs exactly two nibbles per word
  if (nssc_pkg::DATA_W != 2 * nssc_pkg::NIBBLE_W) begin : g_nibble_check
    $error("nssc_datapath: data width must be two nibbles");
  end
  // every operation answers on the edge after it is taken
  if (nssc_pkg::OP_CYCLES != 1) begin : g_cycle_check
    $error("nssc_datapath: only single cycle operation is supported");
  end

  typedef struct packed {
    logic [nssc_pkg::DATA_W-1:0]      acc;
    logic                             carry;
    logic                             done;
    logic                             fwe;
    logic [nssc_pkg::FILE_ADDR_W-1:0] faddr;
    logic [nssc_pkg::DATA_W-1:0]      fdata;
  } nssc_state_s;

  nssc_state_s state_reg;
  nssc_state_s state_next;

  function automatic logic [nssc_pkg::DATA_W-1:0] swap_nibbles(input logic [nssc_pkg::DATA_W-1:0] v);
    swap_nibbles = {v[nssc_pkg::NIBBLE_W-1:0], v[nssc_pkg::DATA_W-1:nssc_pkg::NIBBLE_W]};
  endfunction

  // minuend minus accumulator; carry high means no borrow
  function automatic logic [nssc_pkg::DATA_W:0] sub_no_borrow(input logic [nssc_pkg::DATA_W-1:0] m,
                                                              input logic [nssc_pkg::DATA_W-1:0] s);
    logic [nssc_pkg::DATA_W:0] d;
    d = {1'b0, m} - {1'b0, s};
    sub_no_borrow = {~d[nssc_pkg::DATA_W], d[nssc_pkg::DATA_W-1:0]};
  endfunction

  // taken when valid and not the empty code
  function automatic logic op_taken(input nssc_pkg::nssc_req_s req);
    op_taken = req.valid && (req.op != nssc_pkg::NSSC_OP_NONE);
  endfunction

  // literal subtract ignores dest and always lands in the accumulator
  function automatic logic goes_to_file(input nssc_pkg::nssc_req_s req);
    if (req.op == nssc_pkg::NSSC_OP_SUB_LIT) begin
      goes_to_file = 1'b0;
    end else begin
      goes_to_file = (req.dest == nssc_pkg::DEST_FILE);
    end
  endfunction

  function automatic logic [nssc_pkg::DATA_W-1:0] minuend_of(input nssc_pkg::nssc_req_s req);
    if (req.op == nssc_pkg::NSSC_OP_SUB_LIT) begin
      minuend_of = req.literal;
    end else begin
      minuend_of = req.file_data;
    end
  endfunction

  always_comb begin
    logic [nssc_pkg::DATA_W:0]   diff;
    logic [nssc_pkg::DATA_W-1:0] result;
    diff            = '0;
    result          = '0;
    state_next      = state_reg;
    state_next.fwe  = 1'b0;
    state_next.done = 1'b0;
    if (op_taken(i_req)) begin
      state_next.done = 1'b1;
      case (i_req.op)
        nssc_pkg::NSSC_OP_SWAP: begin
          // flags untouched
          result = swap_nibbles(i_req.file_data);
        end
        nssc_pkg::NSSC_OP_SUB_LIT: begin
          diff             = sub_no_borrow(minuend_of(i_req), state_reg.acc);
          state_next.carry = diff[nssc_pkg::DATA_W];
          result           = diff[nssc_pkg::DATA_W-1:0];
        end
        nssc_pkg::NSSC_OP_SUB_REG: begin
          diff             = sub_no_borrow(minuend_of(i_req), state_reg.acc);
          state_next.carry = diff[nssc_pkg::DATA_W];
          result           = diff[nssc_pkg::DATA_W-1:0];
        end
        default: begin
          result = '0;
        end
      endcase
      if (goes_to_file(i_req)) begin
        // accumulator keeps its value on a file write-back
        state_next.fwe   = 1'b1;
        state_next.faddr = i_req.addr;
        state_next.fdata = result;
      end else begin
        state_next.acc = result;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg.acc   <= nssc_pkg::ACC_RESET;
      state_reg.carry <= nssc_pkg::CARRY_RESET;
      state_reg.done  <= 1'b0;
      state_reg.fwe   <= 1'b0;
      state_reg.faddr <= '0;
      state_reg.fdata <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_acc          = state_reg.acc;
  assign o_carry        = state_reg.carry;
  assign o_done         = state_reg.done;
  assign o_file_wr = '{we: state_reg.fwe, addr: state_reg.faddr, data: state_reg.fdata};

endmodule

// [nssc_partner.sv]
// file register model
`timescale 1ns/100ps
module nssc_partner (input wire logic i_clock, input wire nssc_pkg::nssc_fwr_s i_wr,
  input wire logic [6:0] i_addr, output logic [7:0] o_data);
  logic [7:0] mem [128] = '{default: 8'hC3};
  always @(posedge i_clock) if (i_wr.we) mem[i_wr.addr] <= i_wr.data;
  assign o_data = i_wr.we && i_wr.addr == i_addr ? i_wr.data : mem[i_addr];
endmodule

// [nssc_datapath_sva.sv]
// datapath checker
`timescale 1ns/100ps
module nssc_datapath_sva (input wire logic i_clock, i_rst, o_carry, o_done, input wire logic [7:0] o_acc,
  input wire nssc_pkg::nssc_req_s i_req, input wire nssc_pkg::nssc_fwr_s o_file_wr);
  nssc_pkg::nssc_req_s q;
  logic [7:0] a;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= i_req;
    end
  end
  always_ff @(posedge i_clock) a <= o_acc;
  wire t = q.valid && |q.op, s = t && q.op[1], w = q.dest && q.op != 2;
  wire [8:0] d = {1'b0, q.op[0] ? q.file_data : q.literal} - {1'b0, a};
  wire [7:0] r = s ? d[7:0] : {q.file_data[3:0], q.file_data[7:4]};
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_done_pulse: assert property (o_done == t) else $error("done");
  a_file_dest: assert property (t && w |-> o_file_wr.we && o_file_wr.addr == q.addr) else $error("dest");
  a_file_data: assert property (t && w |-> o_file_wr.data == r && o_acc == a) else $error("data");
  a_acc_dest: assert property (t && !w |-> o_acc == r && !o_file_wr.we) else $error("acc");
  a_sub_carry: assert property (s |-> o_carry == !d[8]) else $error("carry");
  a_carry_keep: assert property (!s |-> $stable(o_carry)) else $error("flag");
  a_idle_quiet: assert property (!t |-> !o_file_wr.we && $stable(o_acc)) else $error("idle");
  a_data_hold: assert property (!o_file_wr.we |-> $stable(o_file_wr.data)) else $error("hold");
  cover property (t && !s && w);
  cover property (t && !s && !w);
  cover property (s && d[8]);
  cover property (s && !d);
endmodule
bind nssc_datapath nssc_datapath_sva chk_u (.i_clock, .i_rst, .o_carry, .o_done, .o_acc, .i_req, .o_file_wr);

// [nssc_datapath_tb.sv]
// datapath bench
`timescale 1ns/100ps
module nssc_datapath_tb;
  logic i_clock = 0, i_rst = 1, ec = 0, ed = 0, ew = 0, c, d;
  logic [7:0] a, fd, m, er, ea = 8'h00;
  nssc_pkg::nssc_req_s rq = '0;
  nssc_pkg::nssc_fwr_s wr;
  int fails, n_checks, cyc;
  nssc_datapath dut_u (.i_clock, .i_rst, .i_req({rq[26:16], fd, rq.literal}), .o_file_wr(wr),
    .o_acc(a), .o_carry(c), .o_done(d));
  nssc_partner p_u (.i_clock, .i_wr(wr), .i_addr(rq.addr), .o_data(fd));
  initial forever #10 i_clock = ~i_clock;
  always @(posedge i_clock) if (++cyc > 999) begin fails++; print_verdict(); end
  function automatic logic [7:0] swp(logic [7:0] x); return {x[3:0], x[7:4]}; endfunction
  task automatic check(logic [7:0] s, e, string n);
    n_checks++;
    if (s !== e) begin fails++; $display("wrong value %s exp %h seen %h", n, e, s); end
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    void'($urandom(59543));
    repeat (20) @(negedge i_clock);
    i_rst = 0;
    repeat (400) begin
      @(negedge i_clock);
      check(a, ea, "acc");
      check({5'h00, c, d, wr.we}, {5'h00, ec, ed, ew}, "flags");
      if (ew) check(wr.data, er, "wdata");
      if (ew) check({1'b0, wr.addr}, {1'b0, rq.addr}, "waddr");
      rq = 27'($urandom);
      if (cyc % 3 == 0) rq.literal = ea;
      #1 m = rq.op[0] ? fd : rq.literal;
      er = rq.op[1] ? m - ea : swp(fd);
      ed = rq.valid && |rq.op;
      ew = ed && rq.dest && rq.op != 2;
      if (ed && rq.op[1]) ec = m >= ea;
      if (ed && !ew) ea = er;
    end
    print_verdict();
  end
endmodule
